/* File: pkg/fifo_host_defs.vh */
`ifndef FIFO_HOST_DEFS_VH
`define FIFO_HOST_DEFS_VH
// Clock period in picoseconds (50 MHz).
`define CLK_PERIOD_PS 20000
// Pulse width of either strobe, ns, fastest grade.
`define STROBE_LOW_NS 65
`define STROBE_LOW_CYC ((`STROBE_LOW_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Recovery after a strobe rises, ns.
`define STROBE_HIGH_NS 15
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Reset pulse width, ns.
`define CLEAR_PULSE_NS 65
`define CLEAR_PULSE_CYC ((`CLEAR_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Strobes high before reset release, ns.
`define CLEAR_SETUP_TIME_NS 45
`define CLEAR_SETUP_CYC ((`CLEAR_SETUP_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Strobes high after reset release, ns.
`define CLEAR_RECOVERY_TIME_NS 15
`define CLEAR_RECOVERY_CYC ((`CLEAR_RECOVERY_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Read strobe high before rewind release, ns.
`define REWIND_SETUP_TIME_NS 45
`define REWIND_SETUP_CYC ((`REWIND_SETUP_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Read strobe high after rewind release, ns.
`define REWIND_RECOVERY_TIME_NS 15
`define REWIND_RECOVERY_CYC ((`REWIND_RECOVERY_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Wait after a flag releases before a strobe, ns.
`define FLAG_RELEASE_NS 10
`define FLAG_RELEASE_CYC ((`FLAG_RELEASE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Access time from read strobe fall, ns.
`define ACCESS_NS 65
`define ACCESS_CYC ((`ACCESS_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Data setup before write strobe rise, ns.
`define DATA_SETUP_NS 20
// Word width and depth of the buffer outside.
`define WORD_BITS 9
`define FIFO_DEPTH 512
`endif

/* File: rtl/skid_buffer.v */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Two-entry buffer; input ready depends only on registered fill level.
module skid_buffer #(
    parameter WIDTH = 9
) (
    input wire ref_clk, // System clock.
    input wire sys_rst, // Synchronous reset, active high.
    input wire in_valid, // Word offered.
    output wire in_ready, // Room for a word.
    input wire [WIDTH-1:0] in_data, // Offered word.
    output wire out_valid, // Word available.
    input wire out_ready, // Drain accepts the word.
    output wire [WIDTH-1:0] out_data // Head word.
);
    reg [WIDTH-1:0] mem_q [0:1]; // Two storage slots.
    reg rd_q; // Head slot index.
    reg wr_q; // Tail slot index.
    reg [1:0] cnt_q; // Fill level, 0 to 2.
    wire push; // Word enters.
    wire pop; // Word leaves.
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Pointers move on every accepted push or pop; fill level only when one comes without the other.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule

/* File: rtl/fifo_host.v */
`timescale 1ns/1ps
`include "fifo_host_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Host controller: resets the buffer, pushes user words through its write
// port, pulls words from its read port into a two-entry buffer, and rewinds.
module fifo_host #(
    parameter WIDTH = `WORD_BITS, // Word width of the buffer outside.
    parameter DEPTH = `FIFO_DEPTH // Depth of the buffer outside.
) (
    input wire ref_clk, // System clock, 50 MHz.
    input wire sys_rst, // Synchronous reset, active high.
    input wire wr_valid, // User offers a word to write.
    input wire [WIDTH-1:0] wr_data, // Word to write.
    output reg wr_ready, // Write taken this cycle.
    output reg [WIDTH-1:0] rd_data, // Word read back.
    output reg rd_valid, // Read word valid.
    input wire rd_ready, // User accepts the read word.
    input wire rewind_req, // Pulse: request a rewind.
    output reg busy, // Bus cycle or reset in progress.
    output reg write_strobe_n, // Write strobe to the buffer.
    output reg read_strobe_n, // Read strobe to the buffer.
    output reg pointer_clear_n, // Reset to the buffer.
    output reg rewind_pulse_n, // Retransmit to the buffer.
    output reg expansion_input_n, // Expansion input, held low.
    output reg [WIDTH-1:0] data_to_fifo, // Data in of the buffer.
    input wire [WIDTH-1:0] data_from_fifo, // Data out of the buffer.
    input wire empty_flag_n, // Empty flag, low when empty.
    input wire full_flag_n // Full flag, low when full.
);
    localparam ST_CLR = 4'h0; // Reset pulse low.
    localparam ST_CLRREC = 4'h1; // Strobes held high after release.
    localparam ST_IDLE = 4'h2; // Waiting for work.
    localparam ST_WLOW = 4'h3; // Write strobe low.
    localparam ST_RLOW = 4'h4; // Read strobe low.
    localparam ST_REC = 4'h5; // Strobe recovery.
    localparam ST_RWLOW = 4'h6; // Rewind pulse low.
    localparam ST_RWREC = 4'h7; // Read held high after rewind.
    // Counts are worked out as integers, then cut to the timer width on purpose.
    localparam integer CLR_NUM = `CLEAR_PULSE_CYC > `CLEAR_SETUP_CYC ?
        `CLEAR_PULSE_CYC : `CLEAR_SETUP_CYC;
    localparam integer CLRREC_NUM = `CLEAR_RECOVERY_CYC;
    localparam integer LOW_NUM = `STROBE_LOW_CYC > `ACCESS_CYC + 1 ?
        `STROBE_LOW_CYC : `ACCESS_CYC + 1;
    localparam integer HIGH_NUM = `STROBE_HIGH_CYC;
    localparam integer RW_NUM = `REWIND_SETUP_CYC;
    localparam integer RWREC_NUM = `REWIND_RECOVERY_CYC;
    localparam integer FLAG_NUM = `FLAG_RELEASE_CYC;
    localparam [7:0] CLR_CYC = CLR_NUM[7:0];
    localparam [7:0] CLRREC_CYC = CLRREC_NUM[7:0];
    localparam [7:0] LOW_CYC = LOW_NUM[7:0];
    localparam [7:0] HIGH_CYC = HIGH_NUM[7:0];
    localparam [7:0] RW_CYC = RW_NUM[7:0];
    localparam [7:0] RWREC_CYC = RWREC_NUM[7:0];
    localparam [7:0] FLAG_CYC = FLAG_NUM[7:0];

    reg [3:0] state_q; // Sequencer state.
    reg [7:0] tmr_q; // Cycles left in the current phase.
    reg ef_s1_q, ef_s2_q; // Empty flag synchroniser.
    reg ff_s1_q, ff_s2_q; // Full flag synchroniser.
    reg [WIDTH-1:0] dq_s1_q, dq_s2_q; // Data bus synchroniser.
    reg [7:0] ef_age_q; // Cycles the empty flag has been high.
    reg [7:0] ff_age_q; // Cycles the full flag has been high.
    reg rw_pend_q; // Rewind request waiting.
    reg cap_q; // Capture strobe into the buffer.
    reg [WIDTH-1:0] cap_data_q; // Word captured at read end.
    wire buf_ready; // Buffer has room.
    wire buf_valid; // Buffer head valid.
    wire [WIDTH-1:0] buf_data; // Buffer head word.
    wire ef_ok; // Empty flag high long enough.
    wire ff_ok; // Full flag high long enough.

    // Saturating age counter of a flag held high.
    function [7:0] age_next;
        input flag_high;
        input [7:0] age;
        begin
            if (!flag_high) begin
                age_next = 8'h00;
            end else if (age == 8'hFF) begin
                age_next = age;
            end else begin
                age_next = age + 8'h01;
            end
        end
    endfunction

    assign ef_ok = ef_s2_q && (ef_age_q >= FLAG_CYC);
    assign ff_ok = ff_s2_q && (ff_age_q >= FLAG_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // Flags and the data bus come from another part, so they pass two stages.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ef_s1_q <= 1'b0;
            ef_s2_q <= 1'b0;
            ff_s1_q <= 1'b0;
            ff_s2_q <= 1'b0;
            dq_s1_q <= {WIDTH{1'b0}};
            dq_s2_q <= {WIDTH{1'b0}};
            ef_age_q <= 8'h00;
            ff_age_q <= 8'h00;
        end else begin
            ef_s1_q <= empty_flag_n;
            ef_s2_q <= ef_s1_q;
            ff_s1_q <= full_flag_n;
            ff_s2_q <= ff_s1_q;
            dq_s1_q <= data_from_fifo;
            dq_s2_q <= dq_s1_q;
            ef_age_q <= age_next(ef_s2_q, ef_age_q);
            ff_age_q <= age_next(ff_s2_q, ff_age_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus sequencer. Reads win over writes so the reader never starves the
    // buffer into overflow; a read is only begun when the skid buffer has room,
    // which is how a stalled consumer holds the device's read port off.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= ST_CLR;
            tmr_q <= CLR_CYC;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            pointer_clear_n <= 1'b0;
            rewind_pulse_n <= 1'b1;
            expansion_input_n <= 1'b0;
            data_to_fifo <= {WIDTH{1'b0}};
            wr_ready <= 1'b0;
            busy <= 1'b1;
            rw_pend_q <= 1'b0;
            cap_q <= 1'b0;
            cap_data_q <= {WIDTH{1'b0}};
        end else begin
            wr_ready <= 1'b0;
            cap_q <= 1'b0;
            // A new request wins over the clear of the pending flag.
            if (rewind_req) begin
                rw_pend_q <= 1'b1;
            end else if (state_q == ST_RWLOW) begin
                rw_pend_q <= 1'b0;
            end
            if (tmr_q != 8'h00) begin
                tmr_q <= tmr_q - 8'h01;
            end
            case (state_q)
                ST_CLR: begin
                    // Strobes already high, so setup is covered by the pulse.
                    if (tmr_q == 8'h00) begin
                        pointer_clear_n <= 1'b1;
                        state_q <= ST_CLRREC;
                        tmr_q <= CLRREC_CYC;
                    end
                end
                ST_CLRREC: begin
                    if (tmr_q == 8'h00) begin
                        state_q <= ST_IDLE;
                        busy <= 1'b0;
                    end
                end
                ST_IDLE: begin
                    if (rw_pend_q) begin
                        // Read strobe is high here; holding the pulse long
                        // enough also covers the rewind setup.
                        rewind_pulse_n <= 1'b0;
                        state_q <= ST_RWLOW;
                        tmr_q <= RW_CYC;
                        busy <= 1'b1;
                    end else if (ef_ok && buf_ready) begin
                        read_strobe_n <= 1'b0;
                        state_q <= ST_RLOW;
                        tmr_q <= LOW_CYC;
                        busy <= 1'b1;
                    end else if (wr_valid && ff_ok) begin
                        write_strobe_n <= 1'b0;
                        data_to_fifo <= wr_data;
                        wr_ready <= 1'b1;
                        state_q <= ST_WLOW;
                        tmr_q <= LOW_CYC;
                        busy <= 1'b1;
                    end
                end
                ST_WLOW: begin
                    // Data has stood the whole pulse, far above its setup.
                    if (tmr_q == 8'h00) begin
                        write_strobe_n <= 1'b1;
                        state_q <= ST_REC;
                        tmr_q <= HIGH_CYC;
                    end
                end
                ST_RLOW: begin
                    // Data is sampled from the synchroniser just before the
                    // strobe rises, once access time plus two stages passed.
                    if (tmr_q == 8'h00) begin
                        read_strobe_n <= 1'b1;
                        cap_q <= 1'b1;
                        cap_data_q <= dq_s2_q;
                        state_q <= ST_REC;
                        tmr_q <= HIGH_CYC;
                    end
                end
                ST_REC: begin
                    // The flags may still be settling from the last cycle;
                    // the release wait in ef_ok and ff_ok covers the window.
                    if (tmr_q == 8'h00) begin
                        state_q <= ST_IDLE;
                        busy <= 1'b0;
                    end
                end
                ST_RWLOW: begin
                    if (tmr_q == 8'h00) begin
                        rewind_pulse_n <= 1'b1;
                        state_q <= ST_RWREC;
                        tmr_q <= RWREC_CYC;
                    end
                end
                ST_RWREC: begin
                    if (tmr_q == 8'h00) begin
                        state_q <= ST_IDLE;
                        busy <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read words queue here so a stalled consumer loses nothing.
    skid_buffer #(
        .WIDTH(WIDTH)
    ) u_buf (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(cap_q),
        .in_ready(buf_ready),
        .in_data(cap_data_q),
        .out_valid(buf_valid),
        .out_ready(rd_ready && !rd_valid),
        .out_data(buf_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output register: holds a word until the consumer takes it.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_valid <= 1'b0;
            rd_data <= {WIDTH{1'b0}};
        end else if (rd_valid && rd_ready) begin
            rd_valid <= 1'b0;
        end else if (!rd_valid && rd_ready && buf_valid) begin
            rd_valid <= 1'b1;
            rd_data <= buf_data;
        end
    end
endmodule

/* File: testbench/fifo_host_monitor.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Port checks on the host: quiet strobes around clear and rewind, flag waits.
module fifo_host_monitor #(
    parameter WIDTH = 9 // Word width.
) (
    input wire ref_clk, // Clock.
    input wire sys_rst, // Reset.
    input wire wr_valid, // Offer.
    input wire [WIDTH-1:0] wr_data, // Offered word.
    input wire wr_ready, // Word taken.
    input wire [WIDTH-1:0] rd_data, // Read word.
    input wire rd_valid, // Read word valid.
    input wire rd_ready, // Drain ready.
    input wire rewind_req, // Rewind request.
    input wire busy, // Busy.
    input wire write_strobe_n, // Write strobe.
    input wire read_strobe_n, // Read strobe.
    input wire pointer_clear_n, // Device reset.
    input wire rewind_pulse_n, // Device rewind.
    input wire expansion_input_n, // Expansion input.
    input wire [WIDTH-1:0] data_to_fifo, // Device data in.
    input wire [WIDTH-1:0] data_from_fifo, // Device data out.
    input wire empty_flag_n, // Empty flag.
    input wire full_flag_n // Full flag.
);
    // Both strobes parked high; the device needs this around clear.
    wire strobes_idle = write_strobe_n & read_strobe_n;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    a_clear_setup_idle: assert property (
        $rose(pointer_clear_n) |-> $past(strobes_idle, 1) && $past(strobes_idle, 2)
        && $past(strobes_idle, 3)) else $error("strobe active before clear release");
    a_clear_recovery_idle: assert property (
        $rose(pointer_clear_n) |-> strobes_idle) else $error("strobe during clear recovery");
    a_no_write_in_clear: assert property (
        !pointer_clear_n |-> write_strobe_n) else $error("write while device held in clear");
    a_expansion_held_low: assert property (
        !pointer_clear_n |-> !expansion_input_n) else $error("expansion input not low");
    a_rewind_setup_idle: assert property (
        $rose(rewind_pulse_n) |-> $past(read_strobe_n, 1) && $past(read_strobe_n, 2)
        && $past(read_strobe_n, 3)) else $error("read strobe low before rewind release");
    a_rewind_recovery_idle: assert property (
        $rose(rewind_pulse_n) |-> read_strobe_n) else $error("read during rewind recovery");
    a_rewind_pulse_width: assert property (
        $fell(rewind_pulse_n) |-> !rewind_pulse_n [*4] ##1 rewind_pulse_n)
        else $error("rewind pulse width wrong");
    a_read_after_flag: assert property (
        $fell(read_strobe_n) |-> $past(empty_flag_n, 1) && $past(empty_flag_n, 2))
        else $error("read begun too soon after empty flag");
    a_write_after_flag: assert property (
        $fell(write_strobe_n) |-> $past(full_flag_n, 1) && $past(full_flag_n, 2))
        else $error("write begun while full");
    a_ready_with_strobe: assert property (
        wr_ready |-> !write_strobe_n && $past(write_strobe_n) && data_to_fifo == $past(wr_data))
        else $error("write handshake and strobe disagree");
    c_write: cover property ($fell(write_strobe_n));
    c_read: cover property ($fell(read_strobe_n));
    c_rewind: cover property ($rose(rewind_pulse_n));
    c_full_release: cover property (!full_flag_n ##1 full_flag_n);
endmodule
bind fifo_host fifo_host_monitor #(.WIDTH(WIDTH)) u_monitor (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rewind_req(rewind_req),
    .busy(busy), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .pointer_clear_n(pointer_clear_n), .rewind_pulse_n(rewind_pulse_n),
    .expansion_input_n(expansion_input_n), .data_to_fifo(data_to_fifo),
    .data_from_fifo(data_from_fifo), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n));

/* File: testbench/fifo_device_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Clockless 512-word buffer device; pointers count started and finished cycles.
module fifo_device_model (
    input wire write_strobe_n, // Write strobe.
    input wire read_strobe_n, // Read strobe.
    input wire pointer_clear_n, // Clear, active low.
    input wire rewind_pulse_n, // Rewind, active low.
    input wire [8:0] data_in, // Data in.
    output wire [8:0] data_out, // Data out.
    output wire empty_flag_n, // Low when empty.
    output wire full_flag_n // Low when full.
);
    reg [8:0] mem [0:511]; // Storage.
    reg [9:0] ws, wp, rs, rp; // Writes/reads started and finished.
    reg [8:0] dq = 9'h0AA; // Pins; released bus shows the inverse of the last word.
    reg wr_ok = 1'b0; // Write cycle accepted.
    reg rd_ok = 1'b0; // Read cycle accepted.
    assign data_out = dq;
    // Flags follow pointer distance only, so wrap needs no special case.
    assign #30 empty_flag_n = pointer_clear_n && (wp != rs);
    assign #30 full_flag_n = !pointer_clear_n || (ws - rp != 10'h200);
    // Clear zeroes both pointers; rewind only the read side.
    always @(pointer_clear_n or rewind_pulse_n) begin
        // A clear drops any cycle under way, so a strobe that rises inside it is void.
        if (!pointer_clear_n) begin
            {ws, wp} = 20'h00000;
            wr_ok = 1'b0;
            rd_ok = 1'b0;
        end
        if (!pointer_clear_n || !rewind_pulse_n) {rs, rp} = 20'h00000;
    end
    // A write counts from its falling edge so full drops during the last write.
    always @(negedge write_strobe_n) begin
        wr_ok = pointer_clear_n && full_flag_n;
        if (wr_ok) ws = ws + 10'h001;
    end
    always @(posedge write_strobe_n) begin
        if (wr_ok && pointer_clear_n) begin
            mem[wp[8:0]] = data_in;
            wp = wp + 10'h001;
        end
        wr_ok = 1'b0;
    end
    // Reads while empty leave the pointers alone; the bus is still inverted when the strobe rises.
    always @(negedge read_strobe_n) begin
        rd_ok = pointer_clear_n && empty_flag_n;
        if (rd_ok) begin
            dq <= #65 mem[rs[8:0]];
            rs = rs + 10'h001;
        end
    end
    // Data held briefly after the strobe rises, then the bus is let go.
    always @(posedge read_strobe_n) begin
        if (rd_ok) rp = rp + 10'h001;
        rd_ok = 1'b0;
        dq <= #5 ~dq;
    end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`include "fifo_host_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Host under test facing the device model; words are scored in order.
module tb;
    reg ref_clk = 1'b0; // Clock.
    reg sys_rst = 1'b1; // Reset.
    reg wr_valid = 1'b0; // Offer.
    reg [8:0] wr_data = 9'h000; // Offered word.
    reg rd_ready = 1'b0; // Drain ready.
    reg rewind_req = 1'b0; // Rewind pulse.
    reg [1:0] rd_mode = 2'h1; // Drain: 0 stall, 1 take, 2 random.
    reg [31:0] rnd; // Random draw.
    wire wr_ready, rd_valid, busy, write_strobe_n, read_strobe_n, pointer_clear_n;
    wire rewind_pulse_n, expansion_input_n, empty_flag_n, full_flag_n;
    wire [8:0] rd_data, data_to_fifo, data_from_fifo;
    integer seed = 82; // Fixed seed.
    integer bad_count = 0;
    integer total_checks = 0;
    integer got_n = 0; // Words received.
    integer acc; // Words accepted by the last push.
    reg [8:0] exp_q [$]; // Words owed to the reader.
    reg [8:0] keep_q [$]; // Copy kept for replay after rewind.
    fifo_host u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rewind_req(rewind_req), .busy(busy),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .pointer_clear_n(pointer_clear_n), .rewind_pulse_n(rewind_pulse_n),
        .expansion_input_n(expansion_input_n), .data_to_fifo(data_to_fifo),
        .data_from_fifo(data_from_fifo), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n));
    fifo_device_model u_dev (.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .pointer_clear_n(pointer_clear_n), .rewind_pulse_n(rewind_pulse_n),
        .data_in(data_to_fifo), .data_out(data_from_fifo), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] want);
        begin
            total_checks = total_checks + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, want);
            end
        end
    endtask
    // First words are corner patterns, the rest random.
    function [8:0] word_at(input integer i);
        reg [31:0] r;
        begin
            r = $random(seed);
            case (i)
                0: word_at = 9'h000;
                1: word_at = 9'h1FF;
                2: word_at = 9'h155;
                default: word_at = r[8:0];
            endcase
        end
    endfunction
    // Offer n words; stops early when one is not taken within the bound.
    task push_words(input integer n);
        integer i, t;
        begin
            acc = 0;
            for (i = 0; i < n && acc == i; i = i + 1) begin
                wr_valid <= 1'b1;
                wr_data <= word_at(i);
                t = 0;
                @(posedge ref_clk);
                while (wr_ready !== 1'b1 && t < 100) begin
                    @(posedge ref_clk);
                    t = t + 1;
                end
                if (wr_ready === 1'b1) begin
                    exp_q.push_back(wr_data);
                    keep_q.push_back(wr_data);
                    acc = acc + 1;
                end
            end
            wr_valid <= 1'b0;
        end
    endtask
    task drain;
        integer t;
        begin
            for (t = 0; t < 20000 && exp_q.size() != 0; t = t + 1) @(posedge ref_clk);
            check(exp_q.size(), 0);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d, mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // Reader side: drives ready per mode and scores every handed-over word.
    always @(posedge ref_clk) begin
        rnd = $random(seed);
        rd_ready <= rd_mode[0] | (rd_mode[1] & rnd[0]);
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            got_n = got_n + 1;
            check(exp_q.size() != 0, 1);
            if (exp_q.size() != 0) check(rd_data, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (40) @(posedge ref_clk);
        check(empty_flag_n, 0);
        check(got_n, 0);
        check(expansion_input_n, 0);
        check(busy, 0);
        rd_mode <= 2'h2;
        push_words(40);
        check(acc, 40);
        drain;
        // Stalled reader: device plus the two-entry buffer must fill, then refuse.
        rd_mode <= 2'h0;
        push_words(`FIFO_DEPTH + 8);
        check(acc, `FIFO_DEPTH + 2);
        check(full_flag_n, 0);
        rd_mode <= 2'h2;
        drain;
        // Words left inside at a mid-run reset must never come out.
        rd_mode <= 2'h0;
        push_words(3);
        sys_rst <= 1'b1;
        repeat (16) @(posedge ref_clk);
        check(busy, 1);
        check(pointer_clear_n, 0);
        exp_q.delete();
        keep_q.delete();
        got_n = 0;
        sys_rst <= 1'b0;
        rd_mode <= 2'h1;
        repeat (60) @(posedge ref_clk);
        check(got_n, 0);
        push_words(5);
        drain;
        rewind_req <= 1'b1;
        @(posedge ref_clk);
        rewind_req <= 1'b0;
        exp_q = keep_q;
        drain;
        complete_run;
    end
endmodule
